// File: rtl/proximity_calibration_scheduler.sv
`timescale 1ns/1ps
// Behaviour
// R1 - Low power wait 200/400/600/800 ms by code.
// R2 - Low power period is sequence plus wait.
// R3 - Raw results readable from word 0x00B on.
// R4 - Per pin route: positive, negative, bias, float.
// R5 - Positive raises code, negative lowers it.
// R6 - Each of eight stages has own routing.
// R7 - Matching code: 00 bad, 01, 10, 11.
// R8 - Host sets 11 when pins share terminal.
// R9 - Proximity stops calibration immediately and holds.
// R10 - Full power hold is count times 16 sequences.
// R11 - Low power hold is count times 4 sequences.
// R12 - Resume only when no approach or touch.
// R13 - Timeout word: full 9..0, low 15..10.
// R14 - Hover threshold is level times 16.
// R15 - Approach threshold is rate times 16.
// R16 - Force recalibration on sustained hover excess.
// R17 - Full power timeout is count times sequences.
// R18 - Low power timeout is count times sequences.
// R19 - Recalibrate on expiry even during proximity.
// R20 - Sequence time is stages times stage time.
// R21 - Comparator one: word1 minus word3 magnitude.
// R22 - Comparator two: average minus ambient magnitude.
// R23 - Proximity is either comparator; rise restarts counters.
// R24 - Counters advance once per completed sequence.
module proximity_calibration_scheduler #(
  parameter int unsigned STAGE_MIN_CYCLES    = prox_cal_pkg::STAGE_MIN_CYCLES,
  parameter int unsigned LP_WAIT_STEP_CYCLES = prox_cal_pkg::LP_WAIT_STEP_CYCLES
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // Host register port.
  input  wire logic [9:0]    reg_addr,
  input  wire logic          reg_wr_en,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_rd_en,
  output logic      [15:0]   reg_rdata,
  // Per stage setup: eight pins of two bits each, stage 0 in the low bits.
  input  wire logic [255:0]  pin_route_select,
  input  wire logic [15:0]   terminal_match_select,
  // Converter and filter datapath results for the stage now converting.
  input  wire logic [15:0]   conv_result,
  input  wire logic [15:0]   ff_word1,
  input  wire logic [15:0]   ff_word3,
  input  wire logic [15:0]   ff_average,
  input  wire logic [15:0]   ambient_value,
  input  wire logic          touch_active,
  // Sequencer status.
  output logic               conv_start,
  output logic      [2:0]    stage_index,
  output logic               seq_done,
  output logic               lp_waiting,
  // Input multiplexer controls.
  output logic      [7:0]    sense_input_pin_pos,
  output logic      [7:0]    sense_input_pin_neg,
  output logic      [7:0]    sense_input_pin_bias,
  output logic      [1:0]    match_mode,
  output logic               match_illegal,
  output logic               match_conflict,
  // Calibration control.
  output logic               prox_active,
  output logic               cal_enable,
  output logic      [7:0]    recal_stage
);

  // Writable control words.
  logic [15:0] pwr_ctrl_reg;     // Power and sequence control.
  logic [15:0] amb_ctrl0_reg;    // Ambient compensation control.
  logic [15:0] prox_thr_reg;     // Proximity thresholds.
  logic [15:0] recal_ctrl_reg;   // Recalibration timeouts.
  logic [15:0] result_reg [8];   // Raw converter results per stage.
  logic [15:0] rdata_reg;        // Registered read data.

  // Sequencer state.
  prox_cal_pkg::seq_state_e state_reg;
  logic [31:0] timer_reg;        // Cycle count within stage or wait.
  logic [2:0]  stage_reg;        // Stage now converting.
  logic        seq_done_reg;     // One cycle pulse per finished sequence.

  // Proximity and calibration state.
  logic [7:0]  prox_stage_reg;   // Proximity flag per stage.
  logic        prox_prev_reg;    // Previous proximity, for rise detect.
  logic [8:0]  hold_cnt_reg;     // Sequences since proximity cleared.
  logic        cal_enable_reg;   // Calibration allowed.
  logic [9:0]  recal_cnt_reg [8];// Excess sequences per stage.
  logic [7:0]  recal_stage_reg;  // One cycle recalibration pulses.

  // Routing outputs.
  logic [7:0]  pin_pos_reg;
  logic [7:0]  pin_neg_reg;
  logic [7:0]  pin_bias_reg;
  logic [1:0]  match_reg;
  logic        match_conflict_reg;

  // Field views of the control words.
  logic        low_power;
  logic [1:0]  lp_wait_sel;
  logic [3:0]  stage_num;
  logic [1:0]  decim;
  logic [3:0]  fp_hold;
  logic [3:0]  lp_hold;
  logic [7:0]  hover_lvl;
  logic [5:0]  approach_rate;
  logic [9:0]  fp_recal;
  logic [5:0]  lp_recal;

  // Magnitude of the difference of two unsigned codes.
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  // Routing code of one pin in one stage.
  function automatic logic [1:0] route_of(input logic [255:0] cfg, input logic [2:0] stg,
                                          input int unsigned pin);
    route_of = cfg[{stg, 5'h00} + 8'(pin * 2) +: 2];
  endfunction

  assign low_power     = pwr_ctrl_reg[prox_cal_pkg::PWR_MODE_LSB +: 2]
                         == prox_cal_pkg::MODE_LOW_POWER;
  assign lp_wait_sel   = pwr_ctrl_reg[prox_cal_pkg::LP_WAIT_LSB +: 2];
  assign stage_num     = pwr_ctrl_reg[prox_cal_pkg::STAGE_NUM_LSB +: 4];
  assign decim         = pwr_ctrl_reg[prox_cal_pkg::DECIM_LSB +: 2];
  assign fp_hold       = amb_ctrl0_reg[prox_cal_pkg::FP_HOLD_LSB +: 4];
  assign lp_hold       = amb_ctrl0_reg[prox_cal_pkg::LP_HOLD_LSB +: 4];
  assign hover_lvl     = prox_thr_reg[prox_cal_pkg::HOVER_LSB +: 8];
  assign approach_rate = prox_thr_reg[prox_cal_pkg::APPROACH_LSB +: 6];
  // R13 timeout fields
  assign fp_recal      = recal_ctrl_reg[prox_cal_pkg::FP_RECAL_LSB +: 10];
  assign lp_recal      = recal_ctrl_reg[prox_cal_pkg::LP_RECAL_LSB +: 6];

  // Stage length follows decimation; wait length follows the low power select.
  logic [31:0] stage_len;
  logic [31:0] wait_len;
  logic        stage_end;
  logic        last_stage;
  logic [2:0]  stage_next;

  // R20 stage time select
  always_comb begin
    if (decim == prox_cal_pkg::DECIM_256) begin
      stage_len = 32'(STAGE_MIN_CYCLES) << 2;
    end else if (decim == prox_cal_pkg::DECIM_128) begin
      stage_len = 32'(STAGE_MIN_CYCLES) << 1;
    end else begin
      stage_len = 32'(STAGE_MIN_CYCLES);
    end
  end

  // R1 wait length table
  assign wait_len   = 32'(LP_WAIT_STEP_CYCLES) * (32'(lp_wait_sel) + 32'h0000_0001);
  assign stage_end  = (state_reg == prox_cal_pkg::SEQ_CONVERT)
                      && (timer_reg == stage_len - 32'h0000_0001);
  // Stage numbers above seven still end at the last physical stage.
  assign last_stage = ({1'b0, stage_reg} >= stage_num) || (stage_reg == 3'h7);
  assign stage_next = (stage_end && !last_stage) ? stage_reg + 3'h1
                    : (stage_end ? 3'h0 : stage_reg);

  // Sequencer: convert each stage in turn, then wait in low power mode.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg    <= prox_cal_pkg::SEQ_CONVERT;
      timer_reg    <= 32'h0000_0000;
      stage_reg    <= 3'h0;
      seq_done_reg <= 1'b0;
    end else begin
      seq_done_reg <= 1'b0;
      unique case (state_reg)
        prox_cal_pkg::SEQ_CONVERT: begin
          if (stage_end) begin
            timer_reg <= 32'h0000_0000;
            stage_reg <= stage_next;
            if (last_stage) begin
              seq_done_reg <= 1'b1;
              // R2 wait appended in low power
              if (low_power) begin
                state_reg <= prox_cal_pkg::SEQ_WAIT;
              end
            end
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
        prox_cal_pkg::SEQ_WAIT: begin
          // R1 inter-sequence delay
          if (timer_reg >= wait_len - 32'h0000_0001) begin
            timer_reg <= 32'h0000_0000;
            state_reg <= prox_cal_pkg::SEQ_CONVERT;
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Register writes from the host.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_ctrl_reg   <= prox_cal_pkg::PWR_CTRL_RST;
      amb_ctrl0_reg  <= prox_cal_pkg::AMB_CTRL0_RST;
      prox_thr_reg   <= prox_cal_pkg::PROX_THR_RST;
      recal_ctrl_reg <= prox_cal_pkg::RECAL_CTRL_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == prox_cal_pkg::ADDR_PWR_CTRL) begin
        pwr_ctrl_reg <= reg_wdata;
      end
      if (reg_addr == prox_cal_pkg::ADDR_AMB_CTRL0) begin
        amb_ctrl0_reg <= reg_wdata;
      end
      if (reg_addr == prox_cal_pkg::ADDR_PROX_THR) begin
        prox_thr_reg <= reg_wdata;
      end
      if (reg_addr == prox_cal_pkg::ADDR_RECAL_CTRL) begin
        recal_ctrl_reg <= reg_wdata;
      end
    end
  end

  // Register reads: one cycle latency, unmapped words read as zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_reg <= prox_cal_pkg::RDATA_NONE;
    end else if (reg_rd_en) begin
      if (reg_addr == prox_cal_pkg::ADDR_PWR_CTRL) begin
        rdata_reg <= pwr_ctrl_reg;
      end else if (reg_addr == prox_cal_pkg::ADDR_AMB_CTRL0) begin
        rdata_reg <= amb_ctrl0_reg;
      end else if (reg_addr == prox_cal_pkg::ADDR_PROX_THR) begin
        rdata_reg <= prox_thr_reg;
      end else if (reg_addr == prox_cal_pkg::ADDR_RECAL_CTRL) begin
        rdata_reg <= recal_ctrl_reg;
      end else if ((reg_addr >= prox_cal_pkg::ADDR_RESULT0)
                   && (reg_addr < prox_cal_pkg::ADDR_RESULT0 + 10'h008)) begin
        // R3 raw result readback
        rdata_reg <= result_reg[3'(reg_addr - prox_cal_pkg::ADDR_RESULT0)];
      end else begin
        rdata_reg <= prox_cal_pkg::RDATA_NONE;
      end
    end
  end

  // Per stage comparators, results and recalibration counters.
  logic [15:0] approach_thr;
  logic [15:0] hover_thr;
  logic        comp_approach;
  logic        comp_hover;
  logic        excess;
  logic        prox_any;
  logic        prox_rise;
  logic [9:0]  recal_limit;

  // R15 approach threshold scale
  assign approach_thr  = 16'(approach_rate) << prox_cal_pkg::THR_SHIFT;
  // R14 hover threshold scale
  assign hover_thr     = 16'(hover_lvl) << prox_cal_pkg::THR_SHIFT;
  // R21 first comparator
  assign comp_approach = abs_diff(ff_word1, ff_word3) > approach_thr;
  // R22 second comparator
  assign comp_hover    = abs_diff(ff_average, ambient_value) > hover_thr;
  // R16 excess over ambient
  assign excess        = (conv_result > ambient_value)
                         && ((conv_result - ambient_value) > hover_thr);
  // R9 all stages monitored
  assign prox_any      = |prox_stage_reg;
  // R23 rise detection
  assign prox_rise     = prox_any && !prox_prev_reg;
  // R17 full power timeout
  // R18 low power timeout
  assign recal_limit   = low_power ? 10'(lp_recal) : fp_recal;

  genvar gs;
  generate
    for (gs = 0; gs < 8; gs++) begin : g_stage
      // Result capture and proximity flag update at the end of this stage.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          result_reg[gs]     <= prox_cal_pkg::RESULT_RST;
          prox_stage_reg[gs] <= 1'b0;
        end else if (stage_end && (stage_reg == 3'(gs))) begin
          result_reg[gs]     <= conv_result;
          // R23 either comparator
          prox_stage_reg[gs] <= comp_approach || comp_hover;
        end
      end

      // Counts consecutive sequences with excess; expiry forces recalibration.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          recal_cnt_reg[gs]   <= 10'h000;
          recal_stage_reg[gs] <= 1'b0;
        end else begin
          recal_stage_reg[gs] <= 1'b0;
          if (prox_rise) begin
            // R23 restart recal counter
            recal_cnt_reg[gs] <= 10'h000;
          end else if (stage_end && (stage_reg == 3'(gs))) begin
            // R24 one step per sequence
            if (!excess) begin
              recal_cnt_reg[gs] <= 10'h000;
            end else if ((recal_limit != 10'h000)
                         && (recal_cnt_reg[gs] + 10'h001 >= recal_limit)) begin
              // R19 recalibrate despite proximity
              recal_stage_reg[gs] <= 1'b1;
              recal_cnt_reg[gs]   <= 10'h000;
            end else if (recal_cnt_reg[gs] != 10'h3FF) begin
              recal_cnt_reg[gs] <= recal_cnt_reg[gs] + 10'h001;
            end
          end
        end
      end
    end
  endgenerate

  // Hold period after proximity clears, counted in sequences of the active mode.
  logic [8:0] hold_target;
  logic       hold_done;

  // R10 full power hold
  // R11 low power hold
  assign hold_target = low_power ? (9'(lp_hold) << prox_cal_pkg::HOLD_LP_SHIFT)
                                 : (9'(fp_hold) << prox_cal_pkg::HOLD_FP_SHIFT);
  assign hold_done   = hold_cnt_reg >= hold_target;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_cnt_reg  <= prox_cal_pkg::HOLD_CNT_MAX;
      prox_prev_reg <= 1'b0;
    end else begin
      prox_prev_reg <= prox_any;
      if (prox_any) begin
        // R23 restart hold counter
        hold_cnt_reg <= 9'h000;
      end else if (seq_done_reg && (hold_cnt_reg != prox_cal_pkg::HOLD_CNT_MAX)) begin
        // R24 advance per sequence
        hold_cnt_reg <= hold_cnt_reg + 9'h001;
      end
    end
  end

  // Calibration enable: off at once on proximity, back after hold if idle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_enable_reg <= 1'b1;
    end else begin
      // R9 stop at once
      // R12 resume only when idle
      cal_enable_reg <= !prox_any && !touch_active && hold_done
                        && !(stage_end && (comp_approach || comp_hover));
    end
  end

  // Multiplexer controls for the stage about to convert.
  logic [7:0] pos_next;
  logic [7:0] neg_next;
  logic [7:0] bias_next;

  always_comb begin
    pos_next  = 8'h00;
    neg_next  = 8'h00;
    bias_next = 8'h00;
    for (int p = 0; p < 8; p++) begin
      // R4 per pin route decode
      // R5 terminal polarity
      pos_next[p]  = route_of(pin_route_select, stage_next, p) == prox_cal_pkg::ROUTE_POS;
      neg_next[p]  = route_of(pin_route_select, stage_next, p) == prox_cal_pkg::ROUTE_NEG;
      bias_next[p] = route_of(pin_route_select, stage_next, p) == prox_cal_pkg::ROUTE_BIAS;
    end
  end

  // R6 switch mux per stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_pos_reg        <= 8'h00;
      pin_neg_reg        <= 8'h00;
      pin_bias_reg       <= 8'h00;
      match_reg          <= prox_cal_pkg::MATCH_BAD;
      match_conflict_reg <= 1'b0;
    end else begin
      pin_pos_reg  <= pos_next;
      pin_neg_reg  <= neg_next;
      pin_bias_reg <= bias_next;
      // R7 matching code per stage
      match_reg    <= terminal_match_select[{stage_next, 1'b0} +: 2];
      // R8 flag shared terminal misuse
      match_conflict_reg <= (($countones(pos_next) > 1) || ($countones(neg_next) > 1))
                            && (terminal_match_select[{stage_next, 1'b0} +: 2]
                                != prox_cal_pkg::MATCH_DIFF);
    end
  end

  // Output drive.
  assign reg_rdata            = rdata_reg;
  assign conv_start           = !sys_rst && (state_reg == prox_cal_pkg::SEQ_CONVERT)
                                && (timer_reg == 32'h0000_0000);
  assign stage_index          = stage_reg;
  assign seq_done             = seq_done_reg;
  assign lp_waiting           = state_reg == prox_cal_pkg::SEQ_WAIT;
  assign sense_input_pin_pos  = pin_pos_reg;
  assign sense_input_pin_neg  = pin_neg_reg;
  assign sense_input_pin_bias = pin_bias_reg;
  assign match_mode           = match_reg;
  assign match_illegal        = match_reg == prox_cal_pkg::MATCH_BAD;
  assign match_conflict       = match_conflict_reg;
  assign prox_active          = prox_prev_reg;
  assign cal_enable           = cal_enable_reg;
  assign recal_stage          = recal_stage_reg;

endmodule // proximity_calibration_scheduler

// File: rtl/prox_cal_pkg.sv
// Shared constants and types for the proximity calibration scheduler.
package prox_cal_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned NUM_STAGES  = 8;
  localparam int unsigned NUM_PINS    = 8;
  localparam int unsigned STAGE_W     = 3;

  // Word addresses of the registers.
  localparam logic [9:0] ADDR_PWR_CTRL   = 10'h000;
  localparam logic [9:0] ADDR_AMB_CTRL0  = 10'h002;
  localparam logic [9:0] ADDR_PROX_THR   = 10'h003;
  localparam logic [9:0] ADDR_RECAL_CTRL = 10'h004;
  localparam logic [9:0] ADDR_RESULT0    = 10'h00B;

  // Reset values of the writable registers.
  localparam logic [15:0] PWR_CTRL_RST   = 16'h0000;
  localparam logic [15:0] AMB_CTRL0_RST  = 16'h0000;
  localparam logic [15:0] PROX_THR_RST   = 16'h0000;
  localparam logic [15:0] RECAL_CTRL_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam logic [15:0] RDATA_NONE     = 16'h0000;

  // Field positions in the power and sequence control word.
  localparam int unsigned PWR_MODE_LSB  = 0;
  localparam int unsigned LP_WAIT_LSB   = 2;
  localparam int unsigned STAGE_NUM_LSB = 4;
  localparam int unsigned DECIM_LSB     = 8;
  localparam logic [1:0]  MODE_LOW_POWER = 2'h2;

  // Field positions in the ambient compensation control word.
  localparam int unsigned FP_HOLD_LSB = 4;
  localparam int unsigned LP_HOLD_LSB = 8;

  // Field positions in the proximity threshold word.
  localparam int unsigned HOVER_LSB    = 0;
  localparam int unsigned APPROACH_LSB = 8;

  // Field positions in the recalibration timeout word.
  localparam int unsigned FP_RECAL_LSB = 0;
  localparam int unsigned LP_RECAL_LSB = 10;

  // Multipliers and threshold scaling.
  localparam int unsigned HOLD_FP_SHIFT = 4;   // Times 16.
  localparam int unsigned HOLD_LP_SHIFT = 2;   // Times 4.
  localparam int unsigned THR_SHIFT     = 4;   // Times 16.
  localparam logic [8:0]  HOLD_CNT_MAX  = 9'h1FF;

  // Decimation codes.
  localparam logic [1:0] DECIM_256 = 2'h0;
  localparam logic [1:0] DECIM_128 = 2'h1;

  // Timing: clock period, shortest stage time and low power wait step.
  localparam int unsigned CLK_PERIOD_PS      = 5000;
  localparam int unsigned STAGE_MIN_TIME_PS  = 768_000_000;  // 0.768 ms.
  localparam int unsigned LP_WAIT_STEP_MS    = 200;
  localparam int unsigned PS_PER_MS          = 1_000_000_000;
  localparam int unsigned STAGE_MIN_CYCLES   = STAGE_MIN_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned LP_WAIT_STEP_CYCLES =
    (LP_WAIT_STEP_MS * (PS_PER_MS / CLK_PERIOD_PS));

  // Input pin routing codes.
  typedef enum logic [1:0] {
    ROUTE_FLOAT = 2'h0,
    ROUTE_NEG   = 2'h1,
    ROUTE_POS   = 2'h2,
    ROUTE_BIAS  = 2'h3
  } route_e;

  // Terminal matching codes.
  typedef enum logic [1:0] {
    MATCH_BAD  = 2'h0,
    MATCH_POS  = 2'h1,
    MATCH_NEG  = 2'h2,
    MATCH_DIFF = 2'h3
  } match_e;

  // Sequencer states.
  typedef enum logic {
    SEQ_CONVERT = 1'b0,
    SEQ_WAIT    = 1'b1
  } seq_state_e;

endpackage : prox_cal_pkg

// File: verification/prox_cal_asserts.sv
`timescale 1ns/1ps
// Port-level timing and decode checks for the scheduler.
module prox_cal_asserts #(
  parameter int unsigned STAGE_MIN_CYCLES    = 8,
  parameter int unsigned LP_WAIT_STEP_CYCLES = 20
) (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Touch input, sequencer and mux outputs.
  input wire logic       touch_active,
  input wire logic       conv_start,
  input wire logic [2:0] stage_index,
  input wire logic       seq_done,
  input wire logic       lp_waiting,
  input wire logic [7:0] sense_input_pin_pos,
  input wire logic [7:0] sense_input_pin_neg,
  input wire logic [7:0] sense_input_pin_bias,
  input wire logic [1:0] match_mode,
  input wire logic       match_illegal,
  // Calibration outputs.
  input wire logic       prox_active,
  input wire logic       cal_enable,
  input wire logic [7:0] recal_stage
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A stage lasts at least eight cycles, so pulses are spaced.
  seq_done_gap_a: assert property (seq_done |=> !seq_done [*7])
    else $error("sequence done pulses too close");
  stage_start_gap_a: assert property (conv_start |=> !conv_start [*7])
    else $error("stage start pulses too close");
  stage_step_a: assert property ($changed(stage_index) |-> conv_start || lp_waiting)
    else $error("stage moved without a stage start");
  wait_quiet_a: assert property (lp_waiting |-> !conv_start)
    else $error("conversion started during low power wait");
  match_flag_a: assert property (match_illegal == (match_mode == 2'h0))
    else $error("illegal match flag disagrees with match code");
  prox_cal_off_a: assert property (prox_active |-> !cal_enable)
    else $error("calibration enabled during proximity");
  touch_hold_a: assert property (touch_active && !cal_enable |=> !cal_enable)
    else $error("calibration resumed while touched");
  recal_pulse_a: assert property (|recal_stage |=> recal_stage == 8'h00 [*7])
    else $error("recalibration pulses too close");
  mux_disjoint_a: assert property (((sense_input_pin_pos & sense_input_pin_neg) == 8'h00)
    && ((sense_input_pin_bias & (sense_input_pin_pos | sense_input_pin_neg)) == 8'h00))
    else $error("pin routed to two nodes at once");
endmodule // prox_cal_asserts
bind proximity_calibration_scheduler prox_cal_asserts #(.STAGE_MIN_CYCLES(STAGE_MIN_CYCLES),
  .LP_WAIT_STEP_CYCLES(LP_WAIT_STEP_CYCLES)) chk (.mclk(mclk), .sys_rst(sys_rst),
  .touch_active(touch_active), .conv_start(conv_start), .stage_index(stage_index),
  .seq_done(seq_done), .lp_waiting(lp_waiting), .sense_input_pin_pos(sense_input_pin_pos),
  .sense_input_pin_neg(sense_input_pin_neg), .sense_input_pin_bias(sense_input_pin_bias),
  .match_mode(match_mode), .match_illegal(match_illegal), .prox_active(prox_active),
  .cal_enable(cal_enable), .recal_stage(recal_stage));

// File: verification/sensor_electrode_model.sv
`timescale 1ns/1ps
// Behavioural electrodes seen through the input mux, ambient at midscale.
module sensor_electrode_model (
  // Mux controls and bench knobs.
  input  wire logic [7:0]  pin_pos,
  input  wire logic [7:0]  pin_neg,
  input  wire logic [7:0]  pressed,
  input  wire logic        approach,
  input  wire logic        excess,
  input  wire logic        touch,
  // Words handed to the scheduler.
  output logic      [15:0] conv_result,
  output logic      [15:0] ff_word1,
  output logic      [15:0] ff_word3,
  output logic      [15:0] ff_average,
  output logic      [15:0] ambient_value,
  output logic             touch_active
);
  // terminal polarity effect
  // A pressed pin on the positive terminal adds a step, on the negative one removes it.
  always_comb begin
    conv_result = 16'h8000 + {4'h0, 4'($countones(pin_pos & pressed)), 8'h00}
                - {4'h0, 4'($countones(pin_neg & pressed)), 8'h00}
                + (excess ? 16'h0800 : 16'h0000);
    ff_word1 = conv_result;
    // An approaching hand shows as a slope between fast filter words.
    ff_word3 = conv_result - (approach ? 16'h0300 : 16'h0000);
    ff_average = 16'h8000;
    ambient_value = 16'h8000;
    touch_active = touch;
  end
endmodule // sensor_electrode_model

// File: verification/proximity_calibration_scheduler_test.sv
`timescale 1ns/1ps
// Self-checking bench: register map, sequence timing, proximity and recalibration.
module proximity_calibration_scheduler_test;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic [9:0]   reg_addr = 10'h000;
  logic         reg_wr_en = 1'b0;
  logic [15:0]  reg_wdata = 16'h0000;
  logic         reg_rd_en = 1'b0;
  logic [255:0] route = {{5{32'hFFFF_FFFF}}, 32'hFFFF_FFF0, 32'hFFFF_FFFD, 32'hFFFF_FFFE};
  logic [15:0]  tmatch = 16'h3FF9;
  logic [7:0]   press = 8'h01;
  logic         approach = 1'b0;
  logic         excess = 1'b0;
  logic         touch = 1'b0;
  logic [15:0]  reg_rdata, conv_result, ff_word1, ff_word3, ff_average, ambient_value;
  logic         touch_active, conv_start, seq_done, lp_waiting, match_illegal, match_conflict;
  logic         prox_active, cal_enable, rd_seen = 1'b0;
  logic [2:0]   stage_index;
  logic [7:0]   pin_pos, pin_neg, pin_bias, recal_stage;
  logic [1:0]   match_mode;
  logic [15:0]  exp_q[$];
  logic [31:0]  seed = 32'h0001_4158;
  int           bad_count = 0, total_checks = 0, cycles = 0, n;
  localparam logic [9:0] ADR [5] = '{10'h000, 10'h002, 10'h003, 10'h004, 10'h3FF};

  always #2.5 mclk = ~mclk;

  proximity_calibration_scheduler #(.STAGE_MIN_CYCLES(8), .LP_WAIT_STEP_CYCLES(20)) dut (.*,
    .pin_route_select(route), .terminal_match_select(tmatch), .sense_input_pin_pos(pin_pos),
    .sense_input_pin_neg(pin_neg), .sense_input_pin_bias(pin_bias));

  sensor_electrode_model sensors (.*, .pressed(press));

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Selects the pulse whose spacing is measured.
  function automatic logic ev(input int w);
    return (w == 0) ? seq_done : recal_stage[0];
  endfunction

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register write, strobe high for one cycle.
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
  endtask

  // One register read; the expected word waits in the queue for the monitor.
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd_en = 1'b0;
  endtask

  // Cycles between two successive pulses of the chosen kind.
  task automatic gap(input int w, output int c);
    c = 0;
    do @(negedge mclk); while (!ev(w) && ++c < 3000);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (!ev(w) && c < 3000);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Read data settles a cycle after the strobe; the oldest note is compared then.
  always @(posedge mclk) rd_seen <= reg_rd_en;
  always @(negedge mclk) begin
    cycles++;
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) rd(ADR[i], 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(ADR[i], seed[15:0]);
      rd(ADR[i], seed[15:0]);
    end
    $display("register map test done");
    for (int d = 0; d < 3; d++) begin
      wr(10'h000, {6'h00, 2'(d), 4'h7, 4'h0});
      gap(0, n);
      gap(0, n);
      check(16'(n), 16'(64 * ((d == 0) ? 4 : 3 - d)));
    end
    for (int s = 0; s < 4; s++) begin
      wr(10'h000, {6'h00, 2'h2, 4'h1, 2'(s), 2'h2});
      gap(0, n);
      gap(0, n);
      check(16'(n), 16'(16 + (s + 1) * 20));
    end
    $display("sequence timing test done");
    wr(10'h000, 16'h0210);
    gap(0, n);
    gap(0, n);
    wr(10'h00B, 16'h1234);
    rd(10'h00B, 16'h8100);
    rd(10'h00C, 16'h7F00);
    $display("result readback test done");
    wr(10'h002, 16'h0010);
    wr(10'h004, 16'h0000);
    wr(10'h003, 16'h3F00);
    approach = 1'b1;
    gap(0, n);
    gap(0, n);
    check({15'h0, prox_active}, 16'h0000);
    wr(10'h003, 16'h2F00);
    gap(0, n);
    gap(0, n);
    check({15'h0, prox_active, cal_enable}, 16'h0002);
    approach = 1'b0;
    n = 0;
    while (!cal_enable && n < 40) begin
      @(negedge mclk);
      n += seq_done;
    end
    check(16'(n >= 15 && n <= 17), 16'h0001);
    $display("proximity hold test done");
    wr(10'h003, 16'h007F);
    wr(10'h004, 16'h0003);
    excess = 1'b1;
    approach = 1'b1;
    touch = 1'b1;
    gap(1, n);
    gap(1, n);
    check(16'(n), 16'h0030);
    wr(10'h004, 16'h0800);
    wr(10'h000, 16'h0212);
    gap(1, n);
    gap(1, n);
    check(16'(n), 16'h0048);
    approach = 1'b0;
    repeat (20) gap(0, n);
    check({15'h0, cal_enable}, 16'h0000);
    touch = 1'b0;
    repeat (3) gap(0, n);
    check({15'h0, cal_enable}, 16'h0001);
    $display("recalibration test done");
    test_done();
  end
endmodule // proximity_calibration_scheduler_test
